/* File: bench/overvoltage_trip_elements_tb.sv */
// self-checking bench for the overvoltage trip block
`timescale 1ns/1ps
`default_nettype none
`include "ovt_consts.svh"
module overvoltage_trip_elements_tb;
	import ovt_pkg::*;
	// ==========================================================
	// signals
	logic               clk;
	logic               arst_n;
	logic [7:0]         addr;
	logic [31:0]        wdata;
	logic               wr;
	logic               rd;
	logic [31:0]        rdata;
	logic [4:0]         trip;
	logic [3:0]         contacts;
	logic               irq;
	logic signed [15:0] va, vb, vc, vn;
	phasor_t            phA, phB, phC, phN;
	int                 nFail, nTests, cycles, n;
	// ==========================================================
	// instances
	vt_front_model i_vt_front_model (.aRe(va), .bRe(vb), .cRe(vc),
		.nRe(vn), .clk(clk), .phaseA(phA), .phaseB(phB), .phaseC(phC),
		.residual(phN));
	// short tick keeps the 200 ms off-delay at 200 cycles
	overvoltage_trip_elements #(.TICK_CYCLES(10)) i_overvoltage_trip_elements (
		.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .phaseA(phA), .phaseB(phB), .phaseC(phC),
		.residual(phN), .trip(trip), .contacts(contacts), .irq(irq));
	// ==========================================================
	// tasks
	task endSim;
		if (nFail == 0 && nTests > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chkVal(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			nFail++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task chkRange(input int got, input int lo, input int hi);
		nTests++;
		if (got < lo || got > hi) begin
			nFail++;
			$display("Error %0t: %0d cycles, want %0d..%0d", $time, got, lo, hi);
		end
	endtask
	task wrReg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rdReg(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chkVal(rdata, exp);
	endtask
	task setV(input int a, input int b, input int c, input int r);
		@(posedge clk);
		va <= 16'(a);
		vb <= 16'(b);
		vc <= 16'(c);
		vn <= 16'(r);
	endtask
	task waitTrip(input int e, input logic v);
		n = 0;
		while (trip[e] !== v && n < 600) begin
			@(posedge clk);
			#1 n++;
		end
	endtask
	task chkTrip(input int e, input logic exp);
		chkVal({31'h00000000, trip[e]}, {31'h00000000, exp});
	endtask
	// gated check, then enable and time the trip; hi of 0 means no trip
	task runEl(input int e, input int thr, input int tim, input int mode,
		input int a, input int b, input int c, input int r,
		input int lo, input int hi);
		wrReg(8'(`REG_THR_BASE + 4 * e), 32'(thr));
		wrReg(8'(`REG_TIME_BASE + 4 * e), 32'(tim));
		setV(a, b, c, r);
		repeat (20) @(posedge clk);
		#1 chkTrip(e, 1'b0);
		wrReg(`REG_CTRL, 32'(mode | (1 << e)));
		if (hi == 0) begin
			repeat (60) @(posedge clk);
			#1 chkTrip(e, 1'b0);
		end else begin
			waitTrip(e, 1'b1);
			chkRange(n, lo, hi);
			@(posedge clk);
			#1 chkVal({28'h0000000, contacts},
				{28'h0000000, e > 1, 2'b00, e == 1});
		end
		wrReg(`REG_CTRL, 32'h00000000);
		@(posedge clk);
		#1 chkTrip(e, 1'b0);
		setV(0, 0, 0, 0);
	endtask
	// ==========================================================
	// clock, reset, watchdog
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			nFail++;
			endSim();
		end
	end
	// ==========================================================
	// tests
	initial begin
		{arst_n, addr, wdata, wr, rd, va, vb, vc, vn} = '0;
		{nFail, nTests, cycles, n} = '0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int a = 0; a < 8'h48; a += 4) rdReg(8'(a), 32'h00000000);
		wrReg(8'h80, 32'hFFFFFFFF);
		rdReg(8'h80, 32'h00000000);
		wrReg(`REG_STATUS, 32'hFFFFFFFF);
		rdReg(`REG_STATUS, 32'h00000000);
		// ground element 1 end to end: contacts, interrupt, off-delay
		wrReg(`REG_CMAP_BASE, 32'h00000002);
		wrReg(8'(`REG_CMAP_BASE + 3 * `REG_STRIDE), 32'h0000001C);
		wrReg(8'(`REG_THR_BASE + 4), 32'd500);
		wrReg(`REG_CTRL, 32'h00000002);
		setV(0, 0, 0, 1000);
		waitTrip(1, 1'b1);
		chkRange(n, 1, 3);
		@(posedge clk);
		#1 chkVal({28'h0000000, contacts}, 32'h00000001);
		chkVal({31'h00000000, irq}, 32'h00000000);
		rdReg(`REG_IRQ_STAT, 32'h00000002);
		wrReg(`REG_IRQ_MASK, 32'h00000002);
		@(posedge clk);
		#1 chkVal({31'h00000000, irq}, 32'h00000001);
		wrReg(`REG_IRQ_STAT, 32'h00000002);
		@(posedge clk);
		#1 chkVal({31'h00000000, irq}, 32'h00000000);
		setV(0, 0, 0, 0);
		waitTrip(1, 1'b0);
		chkRange(n, 200, 213);
		wrReg(8'(`REG_TIME_BASE + 4), 32'd3);
		setV(0, 0, 0, 1000);
		repeat (15) @(posedge clk);
		setV(0, 0, 0, 0);
		@(posedge clk);
		#1 chkTrip(1, 1'b0);
		setV(0, 0, 0, 1000);
		waitTrip(1, 1'b1);
		chkRange(n, 23, 33);
		setV(0, 0, 0, 0);
		repeat (50) @(posedge clk);
		#1 chkTrip(1, 1'b1);
		wrReg(`REG_CTRL, 32'h00000000);
		@(posedge clk);
		#1 chkTrip(1, 1'b0);
		// each element in its modes, boundaries held strict
		runEl(0, 500, 0, 13'h000, 1000, 1000, 1000, 0, 1, 3);
		runEl(0, 500, 0, 13'h020, 1000, 1000, 1000, 0, 0, 0);
		runEl(0, 500, 0, 13'h400, 1000, 0, 0, 0, 0, 0);
		runEl(0, 500, 0, 13'h800, 1000, 0, 0, 0, 1, 3);
		runEl(0, 500, 0, 13'h1000, 0, 0, 1000, 0, 0, 0);
		runEl(1, 100, 0, 13'h040, 300, 0, 0, 0, 0, 0);
		runEl(1, 99, 2, 13'h040, 300, 0, 0, 0, 10, 23);
		runEl(2, 500, 0, 13'h000, 0, 0, 0, 1000, 1, 3);
		runEl(2, 500, 0, 13'h080, 0, 0, 0, 1000, 0, 0);
		runEl(3, 200, 0, 13'h000, 600, 0, 0, 0, 0, 0);
		runEl(3, 150, 10, 13'h000, 600, 0, 0, 0, 90, 103);
		runEl(3, 300, 0, 13'h100, 600, 0, 0, 0, 1, 3);
		runEl(4, 150, 0, 13'h000, 600, 0, 0, 0, 1, 3);
		runEl(4, 300, 0, 13'h200, 600, 0, 0, 0, 1, 3);
		endSim();
	end
endmodule
`default_nettype wire

/* File: bench/vt_front_model.sv */
// voltage transformer front end model feeding the trip block
`timescale 1ns/1ps
`default_nettype none
module vt_front_model (
	input  wire logic signed [15:0] aRe,
	input  wire logic signed [15:0] bRe,
	input  wire logic signed [15:0] cRe,
	input  wire logic signed [15:0] nRe,
	input  wire logic               clk,
	output var  ovt_pkg::phasor_t   phaseA,
	output var  ovt_pkg::phasor_t   phaseB,
	output var  ovt_pkg::phasor_t   phaseC,
	output var  ovt_pkg::phasor_t   residual
);
	import ovt_pkg::*;
	// ==========================================================
	// sampled phasors
	initial {phaseA, phaseB, phaseC, residual} = '0;
	// one frame of converter latency, so a command lands a cycle late
	always @(posedge clk) begin
		phaseA   <= '{re: aRe, im: 16'h0000};
		phaseB   <= '{re: bRe, im: 16'h0000};
		phaseC   <= '{re: cRe, im: 16'h0000};
		residual <= '{re: nRe, im: 16'h0000};
	end
endmodule
`default_nettype wire

/* File: common/ovt_consts.svh */
// named constants for the overvoltage trip elements
`ifndef OVT_CONSTS_SVH
`define OVT_CONSTS_SVH
// ==========================================================
// timing
`define CLK_HZ          10000000
`define TICK_MS         10
`define OFF_DELAY_MS    200
`define INSTANTANEOUS_SETTING_LIMIT_MS   50
`define TICK_CYCLES_DEF (`CLK_HZ / 1000 * `TICK_MS)
`define OFF_TICKS       (`OFF_DELAY_MS / `TICK_MS)
// ==========================================================
// element indices and counts
`define NUM_EL          5
`define NUM_CONTACTS    4
`define EL_PHASE        0
`define EL_GND1         1
`define EL_GND2         2
`define EL_NEG1         3
`define EL_NEG2         4
// ==========================================================
// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_THR_BASE    8'h04
`define REG_TIME_BASE   8'h18
`define REG_STATUS      8'h2C
`define REG_IRQ_STAT    8'h30
`define REG_IRQ_MASK    8'h34
`define REG_CMAP_BASE   8'h38
`define REG_STRIDE      8'h04
// ==========================================================
// control fields and reset values
`define CTRL_EN_LSB     0
`define CTRL_PHSEL      5
`define CTRL_V0SRC_LSB  6
`define CTRL_NEGLN_LSB  8
`define CTRL_LOCK_LSB   10
`define CTRL_W          13
`define STAT_TRIP_LSB   8
`define CTRL_RST        13'h0000
`define THR_RST         12'h000
`define TIME_RST        10'h000
`define CMAP_RST        5'h00
`define MASK_RST        5'h00
// ==========================================================
// arithmetic scale factors
`define ZS_SCALE        4'h3
`define NS_SCALE        4'h6
`define SQRT3_Q14       16'h6EDA
`define SQRT3_SHIFT     14
`endif

/* File: common/ovt_pkg.sv */
// types shared by the overvoltage trip elements
package ovt_pkg;
	typedef struct packed {
		logic signed [15:0] re;
		logic signed [15:0] im;
	} phasor_t;

	typedef struct packed {
		logic signed [23:0] re;
		logic signed [23:0] im;
	} wide_t;

	typedef struct packed {
		logic [9:0] opCnt;
		logic [5:0] offCnt;
		logic       trip;
	} timer_state_t;

	typedef struct packed {
		logic [12:0]      ctrl;
		logic [4:0][11:0] thr;
		logic [4:0][9:0]  opTime;
		logic [4:0]       irqStat;
		logic [4:0]       irqMask;
		logic [3:0][4:0]  cmap;
		logic [4:0]       tripPrev;
		logic [3:0]       contacts;
		logic             irq;
		logic [31:0]      rdata;
		logic [23:0]      tickCnt;
		logic             tick;
	} top_state_t;
endpackage

/* File: rtl/ov_element_timer.sv */
// operate timer, off-delay and enable gate of one element
`timescale 1ns/1ps
`default_nettype none
`include "ovt_consts.svh"
module ov_element_timer #(
	parameter int OFF_TICKS = `OFF_TICKS
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       enable,
	input  wire logic       pickup,
	input  wire logic       tick,
	input  wire logic [9:0] opTime,
	output var  logic       trip
);
	import ovt_pkg::*;

	timer_state_t s;
	timer_state_t n;

	initial begin
		if (OFF_TICKS < 1 || OFF_TICKS > 62)
			$error("OFF_TICKS out of range");
	end

	always_comb begin
		n = s;
		if (!enable) begin
			n = '0;
		end else if (pickup) begin
			n.offCnt = '0;
			if (!s.trip && s.opCnt >= opTime)
				n.trip = 1'b1;
			else if (!s.trip && tick)
				n.opCnt = s.opCnt + 10'h001;
		end else begin
			n.opCnt = '0;
			// full 200 ms guaranteed: release one tick after the count
			if (s.trip && tick) begin
				if (s.offCnt == 6'(OFF_TICKS)) begin
					n.trip = 1'b0;
					n.offCnt = '0;
				end else begin
					n.offCnt = s.offCnt + 6'h01;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			s <= '0;
		else
			s <= n;
	end

	assign trip = s.trip;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	disable_clears_a: assert property (!enable |=> !trip && s.opCnt == 0)
		else $error("trip survived enable off");
	instantaneous_setting_trip_a: assert property (
		enable && pickup && opTime == 0 && !trip |=> trip)
		else $error("instantaneous trip late");
	early_drop_a: assert property (
		enable && !pickup && !trip |=> s.opCnt == 0 && !trip)
		else $error("timer not reset on drop");
	operate_wait_a: assert property (
		enable && !trip && s.opCnt < opTime |=> !trip)
		else $error("trip before operate time");
	hold_off_a: assert property (
		enable && trip && !tick |=> trip)
		else $error("trip dropped between ticks");
	release_count_a: assert property (
		$fell(trip) && $past(enable) |-> $past(s.offCnt) == OFF_TICKS)
		else $error("off-delay too short");
endmodule
`default_nettype wire

/* File: rtl/overvoltage_trip_elements.sv */
// phase, ground-fault and negative-sequence overvoltage trip block
// ==========================================================
// Summary of operation
// - phase element setting picks phase-to-neutral or line voltages.
// - ground elements take zero sequence from (A+B+C)/3 or residual input.
// - ground element above threshold starts timer, trips when time elapses.
// - ground and negative elements hold trip 200 ms after condition clears.
// - ground element trips only while its enable is on.
// - negative elements derive negative sequence from line or phase voltages.
// - negative element above threshold trips after its operate time.
// - negative element output gated by its enable.
// - second independent ground-fault element.
// - second independent negative-sequence element.
// - zero operate time trips within 50 ms.
// - trips reach contacts through programmable OR maps, not fixed wiring.
// - phase element above threshold trips after its operate timer.
// - per-channel lock keeps single phase-to-neutral or line voltages from operating.
`timescale 1ns/1ps
`default_nettype none
`include "ovt_consts.svh"
module overvoltage_trip_elements #(
	parameter int TICK_CYCLES = `TICK_CYCLES_DEF
) (
	input  wire logic               clk,
	input  wire logic               arst_n,
	input  wire logic [7:0]         addr,
	input  wire logic [31:0]        wdata,
	input  wire logic               wr,
	input  wire logic               rd,
	output var  logic [31:0]        rdata,
	input  wire ovt_pkg::phasor_t   phaseA,
	input  wire ovt_pkg::phasor_t   phaseB,
	input  wire ovt_pkg::phasor_t   phaseC,
	input  wire ovt_pkg::phasor_t   residual,
	output var  logic [4:0]         trip,
	output var  logic [3:0]         contacts,
	output var  logic               irq
);
	import ovt_pkg::*;

	localparam int TICK_MAX = 1 << 24;

	initial begin
		if (TICK_CYCLES < 2 || TICK_CYCLES >= TICK_MAX)
			$error("TICK_CYCLES out of range");
		if ((`INSTANTANEOUS_SETTING_LIMIT_MS) < (`TICK_MS))
			$error("tick too coarse for instantaneous limit");
	end

	// ==========================================================
	// reset release
	logic rstMeta_q;
	logic rstSync_n;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_q <= 1'b0;
			rstSync_n <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstSync_n <= rstMeta_q;
		end
	end

	// ==========================================================
	// phasor arithmetic
	function automatic wide_t widen(input phasor_t p);
		wide_t w;
		w.re = 24'(p.re);
		w.im = 24'(p.im);
		return w;
	endfunction

	function automatic wide_t diff(input wide_t a, input wide_t b);
		wide_t w;
		w.re = a.re - b.re;
		w.im = a.im - b.im;
		return w;
	endfunction

	function automatic logic [47:0] magSq(input wide_t p);
		logic signed [47:0] r2;
		logic signed [47:0] i2;
		r2 = 48'(p.re) * 48'(p.re);
		i2 = 48'(p.im) * 48'(p.im);
		return $unsigned(r2 + i2);
	endfunction

	// squared threshold scaled by k; compares avoid any division
	function automatic logic [47:0] thrSq(input logic [11:0] t,
	                                      input logic [3:0]  k);
		logic [47:0] v;
		v = 48'(t) * 48'(k);
		return v * v;
	endfunction

	// six times negative sequence: 2a - b - c + sqrt3 * rotation
	function automatic logic [47:0] negSeq6Sq(input wide_t a,
	                                          input wide_t b,
	                                          input wide_t c);
		logic signed [39:0] p;
		logic signed [39:0] q;
		wide_t              w;
		p = 40'(b.im - c.im) * 40'($signed({1'b0, `SQRT3_Q14}));
		q = 40'(c.re - b.re) * 40'($signed({1'b0, `SQRT3_Q14}));
		w.re = (a.re <<< 1) - b.re - c.re + 24'(p >>> `SQRT3_SHIFT);
		w.im = (a.im <<< 1) - b.im - c.im + 24'(q >>> `SQRT3_SHIFT);
		return magSq(w);
	endfunction

	// ==========================================================
	// derived quantities and pickups
	wide_t       ph [3];
	wide_t       ln [3];
	wide_t       zeroSum;
	logic [4:0]  pickup;
	logic [2:0]  phasePick;
	top_state_t  s;
	top_state_t  n;
	logic [4:0]  elTrip;
	logic [4:0]  enables;
	logic [2:0]  locks;

	assign enables = s.ctrl[`CTRL_EN_LSB +: `NUM_EL];
	assign locks   = s.ctrl[`CTRL_LOCK_LSB +: 3];

	always_comb begin
		ph[0] = widen(phaseA);
		ph[1] = widen(phaseB);
		ph[2] = widen(phaseC);
		ln[0] = diff(ph[0], ph[1]);
		ln[1] = diff(ph[1], ph[2]);
		ln[2] = diff(ph[2], ph[0]);
		zeroSum.re = ph[0].re + ph[1].re + ph[2].re;
		zeroSum.im = ph[0].im + ph[1].im + ph[2].im;
		for (int i = 0; i < 3; i++) begin
			if (s.ctrl[`CTRL_PHSEL])
				phasePick[i] = magSq(ln[i]) > thrSq(s.thr[`EL_PHASE], 4'h1);
			else
				phasePick[i] = magSq(ph[i]) > thrSq(s.thr[`EL_PHASE], 4'h1);
		end
		pickup[`EL_PHASE] = |(phasePick & ~locks);
		for (int g = 0; g < 2; g++) begin
			if (s.ctrl[`CTRL_V0SRC_LSB + g])
				pickup[`EL_GND1 + g] = magSq(zeroSum)
					> thrSq(s.thr[`EL_GND1 + g], `ZS_SCALE);
			else
				pickup[`EL_GND1 + g] = magSq(widen(residual))
					> thrSq(s.thr[`EL_GND1 + g], 4'h1);
		end
		for (int k = 0; k < 2; k++) begin
			if (s.ctrl[`CTRL_NEGLN_LSB + k])
				pickup[`EL_NEG1 + k] = negSeq6Sq(ln[0], ln[1], ln[2])
					> thrSq(s.thr[`EL_NEG1 + k], `NS_SCALE);
			else
				pickup[`EL_NEG1 + k] = negSeq6Sq(ph[0], ph[1], ph[2])
					> thrSq(s.thr[`EL_NEG1 + k], `NS_SCALE);
		end
	end

	// ==========================================================
	// element timers, one per element with independent settings
	genvar e;
	generate
		for (e = 0; e < `NUM_EL; e++) begin : g_el
			ov_element_timer #(
				.OFF_TICKS (`OFF_TICKS)
			) u_timer (
				.clk    (clk),
				.rst_n  (rstSync_n),
				.enable (enables[e]),
				.pickup (pickup[e]),
				.tick   (s.tick),
				.opTime (s.opTime[e]),
				.trip   (elTrip[e])
			);
		end
	endgenerate

	// ==========================================================
	// register file, interrupt and contact logic
	logic [4:0] tripRise;
	logic [4:0] w1c;

	always_comb begin
		n = s;
		n.rdata = '0;
		w1c = '0;
		tripRise = elTrip & ~s.tripPrev;
		n.tripPrev = elTrip;
		// timebase for every operate and off-delay count
		if (s.tickCnt == 24'(TICK_CYCLES - 1)) begin
			n.tickCnt = '0;
			n.tick = 1'b1;
		end else begin
			n.tickCnt = s.tickCnt + 24'h000001;
			n.tick = 1'b0;
		end
		if (wr) begin
			if (addr == `REG_CTRL)
				n.ctrl = wdata[`CTRL_W-1:0];
			if (addr == `REG_IRQ_STAT)
				w1c = wdata[`NUM_EL-1:0];
			if (addr == `REG_IRQ_MASK)
				n.irqMask = wdata[`NUM_EL-1:0];
			for (int i = 0; i < `NUM_EL; i++) begin
				if (addr == `REG_THR_BASE + 8'(i * 4))
					n.thr[i] = wdata[11:0];
				if (addr == `REG_TIME_BASE + 8'(i * 4))
					n.opTime[i] = wdata[9:0];
			end
			for (int c = 0; c < `NUM_CONTACTS; c++) begin
				if (addr == `REG_CMAP_BASE + 8'(c * 4))
					n.cmap[c] = wdata[`NUM_EL-1:0];
			end
		end
		// a trip edge in the clearing cycle stays recorded
		n.irqStat = (s.irqStat & ~w1c) | tripRise;
		n.irq = |(n.irqStat & n.irqMask);
		if (rd) begin
			if (addr == `REG_CTRL)
				n.rdata = 32'(s.ctrl);
			if (addr == `REG_STATUS)
				n.rdata = 32'(pickup) | (32'(elTrip) << `STAT_TRIP_LSB);
			if (addr == `REG_IRQ_STAT)
				n.rdata = 32'(s.irqStat);
			if (addr == `REG_IRQ_MASK)
				n.rdata = 32'(s.irqMask);
			for (int i = 0; i < `NUM_EL; i++) begin
				if (addr == `REG_THR_BASE + 8'(i * 4))
					n.rdata = 32'(s.thr[i]);
				if (addr == `REG_TIME_BASE + 8'(i * 4))
					n.rdata = 32'(s.opTime[i]);
			end
			for (int c = 0; c < `NUM_CONTACTS; c++) begin
				if (addr == `REG_CMAP_BASE + 8'(c * 4))
					n.rdata = 32'(s.cmap[c]);
			end
		end
		for (int c = 0; c < `NUM_CONTACTS; c++)
			n.contacts[c] = |(s.cmap[c] & elTrip);
	end

	always_ff @(posedge clk or negedge rstSync_n) begin
		if (!rstSync_n) begin
			s <= '0;
			s.ctrl <= `CTRL_RST;
			s.thr <= {`NUM_EL{`THR_RST}};
			s.opTime <= {`NUM_EL{`TIME_RST}};
			s.irqMask <= `MASK_RST;
			s.cmap <= {`NUM_CONTACTS{`CMAP_RST}};
		end else begin
			s <= n;
		end
	end

	assign rdata    = s.rdata;
	assign contacts = s.contacts;
	assign irq      = s.irq;
	assign trip     = elTrip;

	// ==========================================================
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstSync_n);

	contact_map_a: assert property (
		##1 contacts[0] == |($past(s.cmap[0]) & $past(elTrip)))
		else $error("contact does not follow its map");
	gnd_gate_a: assert property (
		!enables[`EL_GND1] |=> !trip[`EL_GND1])
		else $error("ground trip with element off");
	neg_gate_a: assert property (
		!enables[`EL_NEG2] |=> !trip[`EL_NEG2])
		else $error("negative trip with element off");
	lock_phase_a: assert property (
		locks == 3'h7 && !trip[`EL_PHASE] |=> !trip[`EL_PHASE])
		else $error("locked phases tripped");
	status_set_a: assert property (
		|tripRise |=> (s.irqStat & $past(tripRise)) == $past(tripRise))
		else $error("trip edge lost from status");
	irq_level_a: assert property (
		irq |-> |(s.irqStat & s.irqMask))
		else $error("interrupt without unmasked status");
	read_idle_a: assert property (!rd |=> rdata == 32'h00000000)
		else $error("read data outside read slot");
endmodule
`default_nettype wire
